// File: rtl/sstx_regs.svh
// Purpose: named constants of the serial audio input link
// Assumes: included by the package and by both ends of the link
// Notes:   sized to the signals they meet
`ifndef SSTX_REGS_SVH
`define SSTX_REGS_SVH

// framing format codes
`define SSTX_FMT_LJ        2'h0
`define SSTX_FMT_I2S       2'h1
`define SSTX_FMT_RJ        2'h2

// word width codes
`define SSTX_WID_16        2'h0
`define SSTX_WID_18        2'h1
`define SSTX_WID_20        2'h2
`define SSTX_WID_24        2'h3

// bits per word
`define SSTX_BITS_16       5'h10
`define SSTX_BITS_18       5'h12
`define SSTX_BITS_20       5'h14
`define SSTX_BITS_24       5'h18

// serial clocks from frame sync transition to msb
`define SSTX_LJ_DLY        6'h00
`define SSTX_I2S_DLY       6'h01
`define SSTX_RJ_DLY_16     6'h10
`define SSTX_RJ_DLY_18     6'h0e
`define SSTX_RJ_DLY_20     6'h0c
`define SSTX_RJ_DLY_24     6'h08

// frame geometry, in serial clocks
`define SSTX_POS_LAST      6'h3f
`define SSTX_WORD_MAX      24

// source divider: clk cycles per serial clock half period
`define SSTX_SCLK_HALF     4'h4

`endif

// File: rtl/sstx_pkg.sv
// Purpose: types and decoders shared by both ends of the link
// Assumes: constants come from sstx_regs.svh
// Notes:   decoders are functions since both ends use them
`include "sstx_regs.svh"

package sstx_pkg;

    typedef enum logic [1:0]
    {
        SSTX_LJ  = `SSTX_FMT_LJ,
        SSTX_I2S = `SSTX_FMT_I2S,
        SSTX_RJ  = `SSTX_FMT_RJ
    } sstx_fmt_type;

    typedef enum logic [1:0]
    {
        SSTX_W16 = `SSTX_WID_16,
        SSTX_W18 = `SSTX_WID_18,
        SSTX_W20 = `SSTX_WID_20,
        SSTX_W24 = `SSTX_WID_24
    } sstx_width_type;

    function automatic logic [4:0] sstx_bits(sstx_width_type w);
        case (w)
            SSTX_W16: return `SSTX_BITS_16;
            SSTX_W18: return `SSTX_BITS_18;
            SSTX_W20: return `SSTX_BITS_20;
            default:  return `SSTX_BITS_24;
        endcase
    endfunction

    // position of the msb within a half frame
    function automatic logic [5:0] sstx_msb_pos(sstx_fmt_type f,
                                                sstx_width_type w);
        case (f)
            SSTX_LJ:  return `SSTX_LJ_DLY;
            SSTX_I2S: return `SSTX_I2S_DLY;
            default:
            begin
                case (w)
                    SSTX_W16: return `SSTX_RJ_DLY_16;
                    SSTX_W18: return `SSTX_RJ_DLY_18;
                    SSTX_W20: return `SSTX_RJ_DLY_20;
                    default:  return `SSTX_RJ_DLY_24;
                endcase
            end
        endcase
    endfunction

    // frame sync level that marks the left channel
    function automatic logic sstx_left_level(sstx_fmt_type f);
        return (f == SSTX_I2S) ? 1'b0 : 1'b1;
    endfunction

endpackage

// File: rtl/sstx_if.sv
// Purpose: three-wire serial audio link between source and formatter
// Assumes: source drives every wire
// Notes:   no clocking block; the formatter's link side runs on sclk
`timescale 1ns/10ps

interface sstx_if;
    logic sclk;
    logic lr_frame_sync;
    logic sdata;

    modport src_mp
    (
        output sclk,
        output lr_frame_sync,
        output sdata
    );

    modport dev_mp
    (
        input  sclk,
        input  lr_frame_sync,
        input  sdata
    );
endinterface

// File: rtl/sstx_formatter.sv
// Purpose: serial audio input formatter of the transmitter
// Assumes: sclk from the source; clk is the system clock
// Notes:   config crosses as quasi-static levels, samples by toggle
`timescale 1ns/10ps

`include "sstx_regs.svh"

module sstx_formatter
    import sstx_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                reset,
    input  wire logic                cfg_write,
    input  wire sstx_fmt_type        cfg_format,
    input  wire sstx_width_type      cfg_width,
    output logic [`SSTX_WORD_MAX-1:0] sample_data,
    output logic                     sample_right,
    output logic                     sample_valid,
    sstx_if.dev_mp                   lnk
);

    // state clocked by the link's serial clock
    typedef struct packed
    {
        logic                      rst_s1;
        logic                      rst_s2;
        logic [1:0]                fmt_s1;
        logic [1:0]                fmt_s2;
        logic [1:0]                wid_s1;
        logic [1:0]                wid_s2;
        logic                      fs_prev;
        logic                      armed;
        logic                      chan_left;
        logic [5:0]                pos;
        logic [4:0]                cnt;
        logic [`SSTX_WORD_MAX-1:0] shift;
        logic [`SSTX_WORD_MAX-1:0] hold;
        logic                      hold_right;
        logic                      toggle;
    } sstx_link_state_type;

    // state clocked by the system clock
    typedef struct packed
    {
        sstx_fmt_type              fmt;
        sstx_width_type            wid;
        logic                      tog_s1;
        logic                      tog_s2;
        logic                      tog_s3;
        logic [`SSTX_WORD_MAX-1:0] data;
        logic                      right;
        logic                      valid;
    } sstx_sys_state_type;

    sstx_link_state_type l_reg;
    sstx_link_state_type l_next;
    sstx_sys_state_type  s_reg;
    sstx_sys_state_type  s_next;

    // link side: framing decode and word capture
    always_comb
    begin
        sstx_fmt_type   fmt;
        sstx_width_type wid;
        logic [4:0]     bits;
        logic [5:0]     msb;
        logic [5:0]     cur;
        logic           trans;
        fmt   = sstx_fmt_type'(l_reg.fmt_s2);
        wid   = sstx_width_type'(l_reg.wid_s2);
        bits  = sstx_bits(wid);
        msb   = sstx_msb_pos(fmt, wid);
        cur   = l_reg.pos;
        trans = 1'b0;

        l_next = l_reg;
        // the first stage of each chain feeds only the second
        l_next.rst_s1 = reset;
        l_next.rst_s2 = l_reg.rst_s1;
        l_next.fmt_s1 = s_reg.fmt;
        l_next.fmt_s2 = l_reg.fmt_s1;
        l_next.wid_s1 = s_reg.wid;
        l_next.wid_s2 = l_reg.wid_s1;

        // sync and data are taken at this rising edge
        l_next.fs_prev = lnk.lr_frame_sync;
        trans = (lnk.lr_frame_sync != l_reg.fs_prev);

        if (trans)
        begin
            // a transition opens a half frame at position zero
            cur             = 6'h00;
            l_next.armed    = 1'b1;
            l_next.cnt      = 5'h00;
            // channel by the sync level of the new half
            l_next.chan_left = (lnk.lr_frame_sync ==
                                sstx_left_level(fmt));
        end
        else if (l_reg.pos != `SSTX_POS_LAST)
        begin
            // saturates so a stalled sync never wraps into a new word
            cur = 6'(l_reg.pos + 6'h01);
        end
        l_next.pos = cur;

        if (l_next.armed && cur == msb)
        begin
            // msb lands at the documented offset for the format
            l_next.shift = {{(`SSTX_WORD_MAX-1){1'b0}}, lnk.sdata};
            l_next.cnt   = 5'h01;
        end
        // a word cut short by an early sync change is dropped rather than
        // finished under the new half's channel tag
        else if (!trans && l_reg.cnt != 5'h00 && l_reg.cnt < bits)
        begin
            l_next.shift = {l_reg.shift[`SSTX_WORD_MAX-2:0], lnk.sdata};
            l_next.cnt   = 5'(l_reg.cnt + 5'h01);
            if (l_next.cnt == bits)
            begin
                // word complete; later bits of the half are dropped
                l_next.hold       = l_next.shift;
                l_next.hold_right = ~l_next.chan_left;
                l_next.toggle     = ~l_reg.toggle;
            end
        end
        // right-justified with 64 clocks per frame ends the word on the
        // clock just before the next transition

        if (l_reg.rst_s2)
        begin
            l_next.fs_prev    = lnk.lr_frame_sync;
            l_next.armed      = 1'b0;
            l_next.chan_left  = 1'b0;
            l_next.pos        = `SSTX_POS_LAST;
            l_next.cnt        = 5'h00;
            l_next.shift      = '0;
            l_next.hold       = '0;
            l_next.hold_right = 1'b0;
            l_next.toggle     = 1'b0;
        end
    end

    always_ff @(posedge lnk.sclk)
    begin
        l_reg <= l_next;
    end

    // system side: configuration and sample hand-off
    always_comb
    begin
        s_next        = s_reg;
        // only the toggle crosses; hold sits still until it is seen
        s_next.tog_s1 = l_reg.toggle;
        s_next.tog_s2 = s_reg.tog_s1;
        s_next.tog_s3 = s_reg.tog_s2;
        s_next.valid  = 1'b0;

        if (s_reg.tog_s2 != s_reg.tog_s3)
        begin
            // hold is stable for a whole half frame after its toggle
            s_next.data  = l_reg.hold;
            s_next.right = l_reg.hold_right;
            s_next.valid = 1'b1;
        end

        if (cfg_write)
        begin
            // changing mid stream may corrupt the words in flight
            s_next.fmt = cfg_format;
            s_next.wid = cfg_width;
        end

        if (reset)
        begin
            s_next.fmt   = SSTX_I2S;
            s_next.wid   = SSTX_W24;
            s_next.data  = '0;
            s_next.right = 1'b0;
            s_next.valid = 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        s_reg <= s_next;
    end

    assign sample_data  = s_reg.data;
    assign sample_right = s_reg.right;
    assign sample_valid = s_reg.valid;

endmodule

// File: rtl/sstx_source.sv
// Purpose: serial audio source end: makes sclk, sync and data
// Assumes: 64 serial clocks per frame, left half first
// Notes:   sclk is clk divided; data changes on falling sclk
`timescale 1ns/10ps

`include "sstx_regs.svh"

module sstx_source
    import sstx_pkg::*;
(
    input  wire logic                      clk,
    input  wire logic                      reset,
    input  wire sstx_fmt_type              cfg_format,
    input  wire sstx_width_type            cfg_width,
    input  wire logic [`SSTX_WORD_MAX-1:0] tx_left,
    input  wire logic [`SSTX_WORD_MAX-1:0] tx_right,
    input  wire logic                      tx_valid,
    output logic                           tx_ready,
    sstx_if.src_mp                         lnk
);

    typedef struct packed
    {
        logic [3:0]                div;
        logic                      sclk;
        logic                      fs;
        logic                      sdata;
        logic [5:0]                pos;
        sstx_fmt_type              fmt;
        sstx_width_type            wid;
        logic [`SSTX_WORD_MAX-1:0] left;
        logic [`SSTX_WORD_MAX-1:0] right;
    } sstx_src_state_type;

    sstx_src_state_type g_reg;
    sstx_src_state_type g_next;
    logic               frame_start;

    always_comb
    begin
        logic [4:0]                k;
        logic [4:0]                s;
        logic [4:0]                n;
        logic [4:0]                idx;
        logic [`SSTX_WORD_MAX-1:0] word;
        logic                      lv;
        k    = 5'h00;
        s    = 5'h00;
        n    = 5'h00;
        idx  = 5'h00;
        word = '0;
        lv   = 1'b0;

        g_next      = g_reg;
        frame_start = 1'b0;
        g_next.div  = 4'(g_reg.div + 4'h1);
        if (g_reg.div == 4'(`SSTX_SCLK_HALF - 4'h1))
        begin
            g_next.div  = 4'h0;
            g_next.sclk = ~g_reg.sclk;
            if (g_reg.sclk)
            begin
                // falling edge: outputs settle before the next rise
                g_next.pos = 6'(g_reg.pos + 6'h01);
                if (g_next.pos == 6'h00)
                begin
                    frame_start = 1'b1;
                    g_next.fmt  = cfg_format;
                    g_next.wid  = cfg_width;
                    g_next.left  = tx_valid ? tx_left  : '0;
                    g_next.right = tx_valid ? tx_right : '0;
                end
                lv = sstx_left_level(g_next.fmt);
                g_next.fs = g_next.pos[5] ? ~lv : lv;
                k    = g_next.pos[4:0];
                s    = 5'(sstx_msb_pos(g_next.fmt, g_next.wid));
                n    = sstx_bits(g_next.wid);
                word = g_next.pos[5] ? g_next.right : g_next.left;
                idx  = 5'(n - 5'h01 - 5'(k - s));
                g_next.sdata = (k >= s && 5'(k - s) < n) ?
                               word[idx] : 1'b0;
            end
        end

        if (reset)
        begin
            g_next.div   = 4'h0;
            g_next.sclk  = 1'b0;
            g_next.fs    = 1'b0;
            g_next.sdata = 1'b0;
            g_next.pos   = `SSTX_POS_LAST;
            g_next.fmt   = SSTX_I2S;
            g_next.wid   = SSTX_W24;
            g_next.left  = '0;
            g_next.right = '0;
            frame_start  = 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        g_reg <= g_next;
    end

    assign tx_ready          = frame_start;
    assign lnk.sclk          = g_reg.sclk;
    assign lnk.lr_frame_sync = g_reg.fs;
    assign lnk.sdata         = g_reg.sdata;

endmodule

// File: sim/sstx_assertions.sv
// Purpose: wire and output checks of the serial audio link
// Assumes: reset is the formatter's reset, released after the source's
// Notes:   half frame length is judged from the second sync change on
`timescale 1ns/10ps

module sstx_assertions
    import sstx_pkg::*;
(
    input wire logic           clk,
    input wire logic           reset,
    input wire logic           sclk,
    input wire logic           lr_frame_sync,
    input wire logic           sdata,
    input wire sstx_width_type cfg_width,
    input wire logic [23:0]    sample_data,
    input wire logic           sample_right,
    input wire logic           sample_valid
);
    logic       sync_d_reg;
    logic       seen_reg;
    logic [5:0] pos_reg;
    logic [4:0] nbits;

    // the first change after reset has no known start, so it only arms
    always_ff @(posedge sclk)
    begin
        sync_d_reg <= lr_frame_sync;
        if (reset)
        begin
            seen_reg <= 1'b0;
            pos_reg  <= 6'h00;
        end
        else if (lr_frame_sync != sync_d_reg)
        begin
            seen_reg <= 1'b1;
            pos_reg  <= 6'h00;
        end
        else if (pos_reg != 6'h3f)
            pos_reg <= pos_reg + 6'h01;
    end

    always_comb
    begin
        case (cfg_width)
            SSTX_W16: nbits = 5'h10;
            SSTX_W18: nbits = 5'h12;
            SSTX_W20: nbits = 5'h14;
            default:  nbits = 5'h18;
        endcase
    end

    sequence s_high_run;
        sclk [*4] ##1 !sclk;
    endsequence

    sequence s_low_run;
        !sclk [*4] ##1 sclk;
    endsequence

    a_sdata_change_low: assert property (
        @(posedge clk) disable iff (reset) $changed(sdata) |-> !sclk)
        else $error("serial data moved while sclk high");
    a_sync_change_low: assert property (
        @(posedge clk) disable iff (reset) $changed(lr_frame_sync) |-> !sclk)
        else $error("frame sync moved while sclk high");
    a_sclk_high_four: assert property (
        @(posedge clk) disable iff (reset) $rose(sclk) |-> s_high_run)
        else $error("sclk high phase not four clocks");
    a_sclk_low_four: assert property (
        @(posedge clk) disable iff (reset) $fell(sclk) |-> s_low_run)
        else $error("sclk low phase not four clocks");
    a_half_frame_len: assert property (
        @(posedge sclk) disable iff (reset)
        seen_reg && (lr_frame_sync != sync_d_reg) |-> pos_reg == 6'h1f)
        else $error("half frame is not 32 serial clocks");
    a_valid_one_clk: assert property (
        @(posedge clk) disable iff (reset) $rose(sample_valid) |=> !sample_valid)
        else $error("sample valid longer than one clock");
    a_word_width_fits: assert property (
        @(posedge clk) disable iff (reset)
        sample_valid |-> (sample_data >> nbits) == 24'h000000)
        else $error("sample wider than configured width");
    a_word_held: assert property (
        @(posedge clk) disable iff (reset)
        !sample_valid |-> $stable(sample_data) && $stable(sample_right))
        else $error("sample changed without valid");
endmodule

// File: sim/testbench.sv
// Purpose: runs source and formatter back to back over the link
// Assumes: sclk is made by the source, so the bench drives clk only
// Notes:   each mode gets a fresh reset so config never moves mid-frame
`timescale 1ns/10ps

module testbench
    import sstx_pkg::*;
    ;
    logic           clk = 1'b0;
    logic           src_reset = 1'b1;
    logic           fmt_reset = 1'b1;
    logic           cfg_write = 1'b0;
    sstx_fmt_type   s_fmt = SSTX_I2S;
    sstx_fmt_type   f_fmt = SSTX_I2S;
    sstx_width_type s_wid = SSTX_W24;
    sstx_width_type f_wid = SSTX_W24;
    logic [23:0]    tx_left = 24'h000000;
    logic [23:0]    tx_right = 24'h000000;
    logic           tx_valid = 1'b1;
    logic           tx_ready;
    logic [23:0]    sample_data;
    logic           sample_right;
    logic           sample_valid;
    int             miscompares = 0;
    int             n_tests = 0;
    int             cycles = 0;

    sstx_if lnk_if ();

    sstx_source i_sstx_source
    (
        .clk        (clk),
        .reset      (src_reset),
        .cfg_format (s_fmt),
        .cfg_width  (s_wid),
        .tx_left    (tx_left),
        .tx_right   (tx_right),
        .tx_valid   (tx_valid),
        .tx_ready   (tx_ready),
        .lnk        (lnk_if)
    );

    sstx_formatter i_sstx_formatter
    (
        .clk          (clk),
        .reset        (fmt_reset),
        .cfg_write    (cfg_write),
        .cfg_format   (f_fmt),
        .cfg_width    (f_wid),
        .sample_data  (sample_data),
        .sample_right (sample_right),
        .sample_valid (sample_valid),
        .lnk          (lnk_if)
    );

    sstx_assertions i_sstx_assertions
    (
        .clk           (clk),
        .reset         (fmt_reset),
        .sclk          (lnk_if.sclk),
        .lr_frame_sync (lnk_if.lr_frame_sync),
        .sdata         (lnk_if.sdata),
        .cfg_width     (f_wid),
        .sample_data   (sample_data),
        .sample_right  (sample_right),
        .sample_valid  (sample_valid)
    );

    always #5 clk = ~clk;

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            miscompares++;
            print_verdict();
        end
    end

    task automatic check(input string name, input logic [23:0] seen,
                         input logic [23:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    function automatic logic [23:0] low_bits(sstx_width_type w,
                                             logic [23:0] v);
        case (w)
            SSTX_W16: return {8'h00, v[15:0]};
            SSTX_W18: return {6'h00, v[17:0]};
            SSTX_W20: return {4'h0, v[19:0]};
            default:  return v;
        endcase
    endfunction

    // source first: the formatter needs sclk edges while held in reset
    task automatic restart(input sstx_fmt_type sf, input sstx_width_type sw,
                           input sstx_fmt_type ff, input sstx_width_type fw,
                           input logic wr);
        @(posedge clk);
        src_reset <= 1'b1;
        fmt_reset <= 1'b1;
        s_fmt <= sf;
        s_wid <= sw;
        f_fmt <= ff;
        f_wid <= fw;
        repeat (12) @(posedge clk);
        src_reset <= 1'b0;
        repeat (100) @(posedge clk);
        fmt_reset <= 1'b0;
        cfg_write <= wr;
        @(posedge clk);
        cfg_write <= 1'b0;
        // two frames let the config land and the partial first word pass
        repeat (1100) @(posedge clk);
    endtask

    task automatic expect_word(input string name, input logic right,
                               input logic [23:0] exp);
        int n;
        n = 0;
        @(negedge clk);
        while (!(sample_valid === 1'b1 && sample_right === right) && n < 1200)
        begin
            @(negedge clk);
            n++;
        end
        check("valid", {23'h000000, sample_valid}, 24'h000001);
        check(name, sample_data, exp);
    endtask

    task automatic t_default_i2s();
        @(posedge clk);
        tx_left <= 24'h9c3a71;
        tx_right <= 24'h63c58e;
        restart(SSTX_I2S, SSTX_W24, SSTX_LJ, SSTX_W24, 1'b0);
        expect_word("default left", 1'b0, 24'h9c3a71);
        expect_word("default right", 1'b1, 24'h63c58e);
    endtask

    task automatic t_all_modes();
        sstx_fmt_type   fm [3] = '{SSTX_LJ, SSTX_I2S, SSTX_RJ};
        sstx_width_type wd [4] = '{SSTX_W16, SSTX_W18, SSTX_W20, SSTX_W24};
        logic [23:0]    el;
        logic [23:0]    er;
        @(posedge clk);
        tx_left <= 24'hb2d4e9;
        tx_right <= 24'h4d2b17;
        foreach (fm[i])
            foreach (wd[j])
            begin
                el = low_bits(wd[j], 24'hb2d4e9);
                er = low_bits(wd[j], 24'h4d2b17);
                restart(fm[i], wd[j], fm[i], wd[j], 1'b1);
                expect_word("mode left", 1'b0, el);
                expect_word("mode right", 1'b1, er);
            end
    endtask

    // source sends 24 bits, formatter keeps only the first 16
    task automatic t_extra_bits();
        @(posedge clk);
        tx_left <= 24'h8e61d3;
        tx_right <= 24'h71a2c5;
        restart(SSTX_LJ, SSTX_W24, SSTX_LJ, SSTX_W16, 1'b1);
        expect_word("cut left", 1'b0, 24'h008e61);
        expect_word("cut right", 1'b1, 24'h0071a2);
    endtask

    task automatic t_silent();
        @(posedge clk);
        tx_valid <= 1'b0;
        restart(SSTX_RJ, SSTX_W20, SSTX_RJ, SSTX_W20, 1'b1);
        expect_word("idle left", 1'b0, 24'h000000);
        expect_word("idle right", 1'b1, 24'h000000);
    endtask

    // one tx_ready pulse per frame: 64 serial clocks of 8 clk each
    task automatic t_frame_rate();
        int n;
        n = 0;
        @(negedge clk);
        while (tx_ready !== 1'b1 && n < 600)
        begin
            @(negedge clk);
            n++;
        end
        n = 0;
        @(negedge clk);
        while (tx_ready !== 1'b1 && n < 600)
        begin
            @(negedge clk);
            n++;
        end
        check("frame period", 24'(n + 1), 24'h000200);
    endtask

    initial
    begin
        t_default_i2s();
        t_all_modes();
        t_extra_bits();
        t_silent();
        t_frame_rate();
        print_verdict();
    end
endmodule
